// File: shared/dma_arb_regs.vh
`ifndef DMA_ARB_REGS_VH
`define DMA_ARB_REGS_VH

// Number of channels; channel 0 is scanned first after reset.
`define NCH 4
`define CH_W 2

// Controller configuration word: global suspend bit.
`define CFG_SUSPEND_BIT 12

// Channel control word fields.
`define CTRL_ON_BIT 7
`define CTRL_EWO_BIT 6
`define CTRL_RANK_MSB 1
`define CTRL_RANK_LSB 0

// Channel event control word: kill bit.
`define ECTRL_KILL_BIT 6

// Reset values.
`define CTRL_RST 8'h00
`define ADDR_RST 32'h00000000
`define SIZE_RST 8'h00

// Staging buffer between read and write: count of bytes plus one word.
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define FIFO_W 35

`endif

// File: hdl/byte_stage_fifo.v
`timescale 1ns/1ns
module byte_stage_fifo #(
	parameter WIDTH = 35,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_nrst,
	// Filling side.
	input wire i_in_valid,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_in_ready,
	// Draining side.
	output wire o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input wire i_out_ready
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_q;
reg [AW-1:0] rd_q;
reg [AW:0] cnt_q;
wire push;
wire pop;

assign o_in_ready = (cnt_q != DEPTH[AW:0]);
assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
assign o_out_data = mem[rd_q];
assign push = i_in_valid & o_in_ready;
assign pop = o_out_valid & i_out_ready;

always @(posedge i_clk) begin
	if (push) begin
		mem[wr_q] <= i_in_data;
	end
end

always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		wr_q <= {AW{1'b0}};
		rd_q <= {AW{1'b0}};
		cnt_q <= {(AW+1){1'b0}};
	end else begin
		if (push) begin
			wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
		end
		if (pop) begin
			rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
		end
		if (push & !pop) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (pop & !push) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
end

endmodule // byte_stage_fifo

// File: hdl/dma_channel_arbiter_aligner.v
// Contract
// - Global suspend bit 12 stops any new bus transaction on all channels at once.
// - Clearing enable mid-transfer finishes current transaction, then that channel stops.
// - Clearing enable keeps pointers and counters so the transfer can resume.
// - Disabled channel still registers events and aborts when events-while-off is set.
// - Device reset returns all channel logic to reset state.
// - Kill write clears enable, zeroes both pointers, resets event detector.
// - Kill lets the running transaction finish and discards the channel's remaining work.
// - Writing source or destination start address zeroes the matching pointer.
// - Two-bit rank in control bits 1:0 ranks channels with pending transfers.
// - Highest active rank is served to cell completion before any lower rank.
// - Equal top-rank channels rotate, one transaction each per turn.
// - Higher rank request waits for the running lower transaction, then takes over.
// - Equal ranks take turns from the last granted channel; no fixed order favours channel 0.
// - Each read fetches the remaining bytes of the addressed 32-bit word, capped at the cell's remaining bytes.
// - With under four source bytes left only those bytes are read.
// - After each write both pointers advance by bytes actually written.
// - Source pointer follows completed writes only, so it may lag reads.
// - Channel flags update together with the pointers after each write.
// - Destination pointer wraps to zero at destination size and writing continues.
// - Each start event moves exactly cell size bytes, then the channel idles.
// - After the larger of source and destination size, clear enable and pointers.
`timescale 1ns/1ns
`include "dma_arb_regs.vh"
module dma_channel_arbiter_aligner (
	// Clock and reset.
	input wire i_clk,
	input wire i_nrst,
	// Controller configuration word, a level from software.
	input wire [15:0] i_cfg_word,
	// Channel control word writes.
	input wire [`NCH-1:0] i_ctrl_wr,
	input wire [7:0] i_ctrl_data,
	// Channel event control word writes.
	input wire [`NCH-1:0] i_ectrl_wr,
	input wire [7:0] i_ectrl_data,
	// Start address and size writes.
	input wire [`NCH-1:0] i_ssa_wr,
	input wire [`NCH-1:0] i_dsa_wr,
	input wire [31:0] i_addr_data,
	input wire [`NCH-1:0] i_size_wr,
	input wire [7:0] i_src_size,
	input wire [7:0] i_dst_size,
	input wire [7:0] i_cell_size,
	// Start and abort requests, one-cycle pulses.
	input wire [`NCH-1:0] i_start_evt,
	input wire [`NCH-1:0] i_abort_evt,
	// Channel status.
	output wire [`NCH-1:0] o_ch_on,
	output wire [`NCH*8-1:0] o_src_ptr,
	output wire [`NCH*8-1:0] o_dst_ptr,
	output wire [`NCH-1:0] o_cell_done,
	output wire [`NCH-1:0] o_block_done,
	// System bus master.
	output wire o_bus_req,
	output wire o_bus_we,
	output wire [31:0] o_bus_addr,
	output wire [3:0] o_bus_be,
	output wire [31:0] o_bus_wdata,
	input wire i_bus_ack,
	input wire [31:0] i_bus_rdata
);

////////////////////////////////////////////////////////////////////////////////

localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_READ = 3'b010;
localparam [2:0] S_WRITE = 3'b100;

reg [2:0] state_q;
reg [`CH_W-1:0] cur_q;
reg [`CH_W-1:0] last_q;
reg bus_req_q;
reg bus_we_q;
reg [31:0] bus_addr_q;
reg [3:0] bus_be_q;
reg [31:0] bus_wdata_q;
reg [2:0] n_q;
reg [1:0] b_q;
reg [2:0] k_q;

wire suspend = i_cfg_word[`CFG_SUSPEND_BIT];
wire busy = (state_q != S_IDLE);
wire wr_done = (state_q == S_WRITE) & bus_req_q & i_bus_ack;
wire [8:0] wn9 = {6'h00, n_q};

wire [`NCH-1:0] pend;
wire [`NCH-1:0] go;
wire [`NCH*2-1:0] rank_all;
wire [`NCH*32-1:0] saddr_all;
wire [`NCH*32-1:0] daddr_all;
wire [`NCH*9-1:0] srem_all;
wire [`NCH*9-1:0] drem_all;
wire [`NCH*9-1:0] crem_all;

wire fifo_in_ready;
wire fifo_out_valid;
wire [`FIFO_W-1:0] fifo_out_data;
wire fifo_push = (state_q == S_READ) & bus_req_q & i_bus_ack;
reg fifo_pop;

////////////////////////////////////////////////////////////////////////////////

genvar g;
generate
	for (g = 0; g < `NCH; g = g + 1) begin : ch
		reg on_q;
		reg ewo_q;
		reg [1:0] rank_q;
		reg [31:0] ssa_q;
		reg [31:0] dsa_q;
		reg [7:0] ssz_q;
		reg [7:0] dsz_q;
		reg [7:0] csz_q;
		reg [7:0] sptr_q;
		reg [7:0] dptr_q;
		reg [8:0] ccnt_q;
		reg [8:0] tot_q;
		reg evt_q;
		reg kill_q;
		reg abrt_q;
		reg cdone_q;
		reg bdone_q;
		// A zero size field means 256 bytes.
		wire [8:0] ssz9 = {ssz_q == 8'h00, ssz_q};
		wire [8:0] dsz9 = {dsz_q == 8'h00, dsz_q};
		wire [8:0] csz9 = {csz_q == 8'h00, csz_q};
		wire [8:0] bsz9 = (ssz9 > dsz9) ? ssz9 : dsz9;
		wire mine = busy & (cur_q == g);
		wire listen = on_q | ewo_q;
		wire upd = wr_done & (cur_q == g);
		wire [8:0] sn = {1'b0, sptr_q} + wn9;
		wire [8:0] dn = {1'b0, dptr_q} + wn9;
		wire [8:0] cn = ccnt_q + wn9;
		wire [8:0] tn = tot_q + wn9;
		wire cfin = upd & (cn == csz9);
		wire bfin = upd & (tn == bsz9);
		always @(posedge i_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				on_q <= 1'b0;
				ewo_q <= 1'b0;
				rank_q <= 2'h0;
				ssa_q <= `ADDR_RST;
				dsa_q <= `ADDR_RST;
				ssz_q <= `SIZE_RST;
				dsz_q <= `SIZE_RST;
				csz_q <= `SIZE_RST;
				sptr_q <= 8'h00;
				dptr_q <= 8'h00;
				ccnt_q <= 9'h000;
				tot_q <= 9'h000;
				evt_q <= 1'b0;
				kill_q <= 1'b0;
				abrt_q <= 1'b0;
				cdone_q <= 1'b0;
				bdone_q <= 1'b0;
			end else begin
				cdone_q <= cfin;
				bdone_q <= bfin;
				if (i_ctrl_wr[g]) begin
					// Pointers and counters are left alone here.
					on_q <= i_ctrl_data[`CTRL_ON_BIT];
					ewo_q <= i_ctrl_data[`CTRL_EWO_BIT];
					rank_q <= i_ctrl_data[`CTRL_RANK_MSB:`CTRL_RANK_LSB];
				end
				// Block progress restarts with the pointers, or a reused channel never completes.
				if (i_ssa_wr[g]) begin
					ssa_q <= i_addr_data;
					sptr_q <= 8'h00;
					tot_q <= 9'h000;
				end
				if (i_dsa_wr[g]) begin
					dsa_q <= i_addr_data;
					dptr_q <= 8'h00;
					tot_q <= 9'h000;
				end
				if (i_size_wr[g]) begin
					ssz_q <= i_src_size;
					dsz_q <= i_dst_size;
					csz_q <= i_cell_size;
				end
				if (upd) begin
					// Pointers move only on writes, so source may lag the read.
					sptr_q <= (sn == ssz9) ? 8'h00 : sn[7:0];
					dptr_q <= (dn == dsz9) ? 8'h00 : dn[7:0];
					ccnt_q <= cfin ? 9'h000 : cn;
					tot_q <= bfin ? 9'h000 : tn;
					if (cfin) begin
						evt_q <= 1'b0;
					end
					if (bfin) begin
						on_q <= 1'b0;
						evt_q <= 1'b0;
						ccnt_q <= 9'h000;
						sptr_q <= 8'h00;
						dptr_q <= 8'h00;
					end
				end
				// A start arriving as the cell closes is kept.
				if (i_start_evt[g] & listen) begin
					evt_q <= 1'b1;
				end
				// Kill and abort wait for the channel's own transaction to end.
				if ((kill_q | abrt_q) & !mine) begin
					on_q <= 1'b0;
					evt_q <= 1'b0;
					kill_q <= 1'b0;
					abrt_q <= 1'b0;
					if (kill_q) begin
						sptr_q <= 8'h00;
						dptr_q <= 8'h00;
						ccnt_q <= 9'h000;
						tot_q <= 9'h000;
					end
				end
				// Requests are taken after the apply step, so one arriving as another is
				// applied stays pending instead of being lost.
				if (i_ectrl_wr[g] & i_ectrl_data[`ECTRL_KILL_BIT]) begin
					kill_q <= 1'b1;
				end
				if (i_abort_evt[g] & listen) begin
					abrt_q <= 1'b1;
				end
			end
		end
		assign pend[g] = on_q & evt_q & !kill_q & !abrt_q;
		assign go[g] = on_q & !kill_q & !abrt_q;
		assign rank_all[g*2 +: 2] = rank_q;
		assign saddr_all[g*32 +: 32] = ssa_q + {24'h000000, sptr_q};
		assign daddr_all[g*32 +: 32] = dsa_q + {24'h000000, dptr_q};
		assign srem_all[g*9 +: 9] = ssz9 - {1'b0, sptr_q};
		assign drem_all[g*9 +: 9] = dsz9 - {1'b0, dptr_q};
		assign crem_all[g*9 +: 9] = csz9 - ccnt_q;
		assign o_ch_on[g] = on_q;
		assign o_src_ptr[g*8 +: 8] = sptr_q;
		assign o_dst_ptr[g*8 +: 8] = dptr_q;
		assign o_cell_done[g] = cdone_q;
		assign o_block_done[g] = bdone_q;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////

// Rotation starts just after the last granted channel; strict compare keeps
// the first of equal ranks, so equals take turns one transaction each.
reg [`CH_W-1:0] pick;
reg found;
reg [1:0] best;
integer k;
integer idx;
always @* begin
	pick = {`CH_W{1'b0}};
	found = 1'b0;
	best = 2'h0;
	idx = 0;
	for (k = 1; k <= `NCH; k = k + 1) begin
		idx = (last_q + k) % `NCH;
		if (pend[idx] & (!found | (rank_all[idx*2 +: 2] > best))) begin
			found = 1'b1;
			best = rank_all[idx*2 +: 2];
			pick = idx[`CH_W-1:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

// Read sizing for the granted channel.
wire [31:0] cs_addr = saddr_all[cur_q*32 +: 32];
wire [8:0] srem = srem_all[cur_q*9 +: 9];
wire [8:0] crem = crem_all[cur_q*9 +: 9];
wire [1:0] rb = cs_addr[1:0];
wire [8:0] avail = 9'h004 - {7'h00, rb};
wire [8:0] rmin1 = (avail < srem) ? avail : srem;
wire [8:0] rmin = (rmin1 < crem) ? rmin1 : crem;
wire [2:0] rn = rmin[2:0];
wire [3:0] rmask = (4'h1 << rn) - 4'h1;

// Write sizing: stay inside one destination word and before the wrap point.
wire [31:0] cd_addr = daddr_all[cur_q*32 +: 32];
wire [8:0] drem = drem_all[cur_q*9 +: 9];
wire [1:0] db = cd_addr[1:0];
wire [8:0] dspace4 = 9'h004 - {7'h00, db};
wire [8:0] dspace = (dspace4 < drem) ? dspace4 : drem;
wire [2:0] left = fifo_out_data[34:32] - k_q;
wire [2:0] wn = (dspace < {6'h00, left}) ? dspace[2:0] : left;
wire [3:0] wmask = (4'h1 << wn) - 4'h1;
wire [31:0] wrest = fifo_out_data[31:0] >> {k_q[1:0], 3'b000};

////////////////////////////////////////////////////////////////////////////////

always @* begin
	fifo_pop = wr_done & (k_q + n_q == fifo_out_data[34:32]);
end

always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		state_q <= S_IDLE;
		cur_q <= {`CH_W{1'b0}};
		last_q <= {`CH_W{1'b1}};
		bus_req_q <= 1'b0;
		bus_we_q <= 1'b0;
		bus_addr_q <= 32'h00000000;
		bus_be_q <= 4'h0;
		bus_wdata_q <= 32'h00000000;
		n_q <= 3'h0;
		b_q <= 2'h0;
		k_q <= 3'h0;
	end else begin
		case (state_q)
			S_IDLE: begin
				// Re-arbitrate only between transactions.
				if (!suspend & found) begin
					cur_q <= pick;
					last_q <= pick;
					state_q <= S_READ;
				end
			end
			S_READ: begin
				if (!bus_req_q) begin
					if (!go[cur_q]) begin
						state_q <= S_IDLE;
					end else if (!suspend & fifo_in_ready) begin
						bus_req_q <= 1'b1;
						bus_we_q <= 1'b0;
						bus_addr_q <= {cs_addr[31:2], 2'b00};
						bus_be_q <= rmask << rb;
						n_q <= rn;
						b_q <= rb;
					end
				end else if (i_bus_ack) begin
					bus_req_q <= 1'b0;
					bus_be_q <= 4'h0;
					k_q <= 3'h0;
					state_q <= S_WRITE;
				end
			end
			S_WRITE: begin
				if (!bus_req_q) begin
					// The write side may stall under suspend while data stays staged.
					if (!suspend & fifo_out_valid) begin
						bus_req_q <= 1'b1;
						bus_we_q <= 1'b1;
						bus_addr_q <= {cd_addr[31:2], 2'b00};
						bus_be_q <= wmask << db;
						bus_wdata_q <= wrest << {db, 3'b000};
						n_q <= wn;
					end
				end else if (i_bus_ack) begin
					bus_req_q <= 1'b0;
					bus_we_q <= 1'b0;
					bus_be_q <= 4'h0;
					k_q <= k_q + n_q;
					if (fifo_pop) begin
						state_q <= S_IDLE;
					end
				end
			end
			default: begin
				state_q <= S_IDLE;
				bus_req_q <= 1'b0;
			end
		endcase
	end
end

byte_stage_fifo #(
	.WIDTH(`FIFO_W),
	.DEPTH(`FIFO_DEPTH),
	.AW(`FIFO_AW)
) u_stage (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_in_valid(fifo_push),
	.i_in_data({n_q, i_bus_rdata >> {b_q, 3'b000}}),
	.o_in_ready(fifo_in_ready),
	.o_out_valid(fifo_out_valid),
	.o_out_data(fifo_out_data),
	.i_out_ready(fifo_pop)
);

assign o_bus_req = bus_req_q;
assign o_bus_we = bus_we_q;
assign o_bus_addr = bus_addr_q;
assign o_bus_be = bus_be_q;
assign o_bus_wdata = bus_wdata_q;

endmodule // dma_channel_arbiter_aligner

// File: testbench/dma_arb_monitor.sv
`timescale 1ns/1ns
`include "dma_arb_regs.vh"
module dma_arb_monitor (
	// Clock, reset and control writes.
	input wire i_clk,
	input wire i_nrst,
	input wire [15:0] i_cfg_word,
	input wire [`NCH-1:0] i_ectrl_wr,
	input wire [7:0] i_ectrl_data,
	input wire [`NCH-1:0] i_ssa_wr,
	input wire [`NCH-1:0] i_dsa_wr,
	// Status and bus.
	input wire [`NCH-1:0] o_ch_on,
	input wire [`NCH*8-1:0] o_src_ptr,
	input wire [`NCH*8-1:0] o_dst_ptr,
	input wire [`NCH-1:0] o_cell_done,
	input wire [`NCH-1:0] o_block_done,
	input wire o_bus_req,
	input wire o_bus_we,
	input wire [31:0] o_bus_addr,
	input wire [3:0] o_bus_be,
	input wire i_bus_ack
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////////////////////////////////////////////
	req_hold_a: assert property (o_bus_req && !i_bus_ack |=> o_bus_req && $stable({o_bus_we, o_bus_addr, o_bus_be}))
		else $error("request changed before ack");
	req_drop_a: assert property (o_bus_req && i_bus_ack |=> !o_bus_req)
		else $error("request stayed after ack");
	suspend_hold_a: assert property (!o_bus_req && i_cfg_word[`CFG_SUSPEND_BIT] |=> !o_bus_req)
		else $error("request issued while suspended");
	addr_align_a: assert property (o_bus_req |-> o_bus_addr[1:0] == 2'h0 && o_bus_be != 4'h0)
		else $error("unaligned or empty request");
	lane_run_a: assert property (o_bus_req |-> o_bus_be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7,
		4'h8, 4'hC, 4'hE, 4'hF})
		else $error("byte lanes not one run");
	kill_clear_a: assert property (i_ectrl_wr[0] && i_ectrl_data[`ECTRL_KILL_BIT] |-> ##[1:30]
		(!o_ch_on[0] && o_src_ptr[7:0] == 8'h00 && o_dst_ptr[7:0] == 8'h00))
		else $error("kill did not clear channel");
	src_zero_a: assert property (i_ssa_wr[0] |=> o_src_ptr[7:0] == 8'h00)
		else $error("source pointer kept after start write");
	dst_zero_a: assert property (i_dsa_wr[0] |=> o_dst_ptr[7:0] == 8'h00)
		else $error("destination pointer kept after start write");
	block_off_a: assert property (o_block_done[0] |-> !o_ch_on[0] && o_src_ptr[7:0] == 8'h00)
		else $error("block end left channel on");
	cell_after_a: assert property (o_cell_done != 4'h0 |-> $past(i_bus_ack && o_bus_we))
		else $error("cell flag not after a write");
endmodule // dma_arb_monitor

bind dma_channel_arbiter_aligner dma_arb_monitor u_dma_arb_monitor (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_cfg_word(i_cfg_word), .i_ectrl_wr(i_ectrl_wr), .i_ectrl_data(i_ectrl_data),
	.i_ssa_wr(i_ssa_wr), .i_dsa_wr(i_dsa_wr), .o_ch_on(o_ch_on), .o_src_ptr(o_src_ptr),
	.o_dst_ptr(o_dst_ptr), .o_cell_done(o_cell_done), .o_block_done(o_block_done),
	.o_bus_req(o_bus_req), .o_bus_we(o_bus_we), .o_bus_addr(o_bus_addr), .o_bus_be(o_bus_be),
	.i_bus_ack(i_bus_ack));

// File: testbench/bus_mem_model.sv
`timescale 1ns/1ns
module bus_mem_model (
	// Clock, reset and stall length.
	input wire i_clk,
	input wire i_nrst,
	input wire [1:0] i_wait,
	// Bus from the engine.
	input wire i_req,
	input wire i_we,
	input wire [31:0] i_addr,
	input wire [3:0] i_be,
	input wire [31:0] i_wdata,
	output logic o_ack,
	output logic [31:0] o_rdata
);
	logic [7:0] mem [0:65535];
	logic [1:0] cnt;
	int rd_bytes = 0;
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
	end
	// Read data is inverted outside acks so stale data can never pass for fresh.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ack <= 1'b0;
			o_rdata <= 32'h0;
			cnt <= 2'h0;
		end else if (o_ack) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
		end else if (i_req && cnt != i_wait) begin
			cnt <= cnt + 2'h1;
		end else if (i_req) begin
			cnt <= 2'h0;
			o_ack <= 1'b1;
			for (int b = 0; b < 4; b++) begin
				o_rdata[8*b+:8] <= mem[{i_addr[15:2], b[1:0]}];
				if (i_be[b] && i_we) mem[{i_addr[15:2], b[1:0]}] <= i_wdata[8*b+:8];
				if (i_be[b] && !i_we) rd_bytes = rd_bytes + 1;
			end
		end
	end
endmodule // bus_mem_model

// File: testbench/dma_channel_arbiter_aligner_test.sv
`timescale 1ns/1ns
`include "dma_arb_regs.vh"
module dma_channel_arbiter_aligner_test;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [15:0] i_cfg_word = 16'h0000;
	logic [3:0] i_ctrl_wr = 4'h0, i_ectrl_wr = 4'h0, i_ssa_wr = 4'h0, i_dsa_wr = 4'h0;
	logic [3:0] i_size_wr = 4'h0, i_start_evt = 4'h0, i_abort_evt = 4'h0;
	logic [7:0] i_ctrl_data = 8'h00, i_ectrl_data = 8'h00;
	logic [7:0] i_src_size = 8'h00, i_dst_size = 8'h00, i_cell_size = 8'h00;
	logic [31:0] i_addr_data = 32'h0;
	logic [1:0] bus_wait = 2'h0;
	wire [3:0] o_ch_on, o_cell_done, o_block_done, o_bus_be;
	wire [31:0] o_src_ptr, o_dst_ptr, o_bus_addr, o_bus_wdata, i_bus_rdata;
	wire o_bus_req, o_bus_we, i_bus_ack;
	int err_count = 0;
	int checks_done = 0;
	logic [3:0] rd_log [$];
	always #20 i_clk = ~i_clk;
	dma_channel_arbiter_aligner u_dma_channel_arbiter_aligner (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_cfg_word(i_cfg_word), .i_ctrl_wr(i_ctrl_wr), .i_ctrl_data(i_ctrl_data),
		.i_ectrl_wr(i_ectrl_wr), .i_ectrl_data(i_ectrl_data), .i_ssa_wr(i_ssa_wr),
		.i_dsa_wr(i_dsa_wr), .i_addr_data(i_addr_data), .i_size_wr(i_size_wr),
		.i_src_size(i_src_size), .i_dst_size(i_dst_size), .i_cell_size(i_cell_size),
		.i_start_evt(i_start_evt), .i_abort_evt(i_abort_evt), .o_ch_on(o_ch_on),
		.o_src_ptr(o_src_ptr), .o_dst_ptr(o_dst_ptr), .o_cell_done(o_cell_done),
		.o_block_done(o_block_done), .o_bus_req(o_bus_req), .o_bus_we(o_bus_we),
		.o_bus_addr(o_bus_addr), .o_bus_be(o_bus_be), .o_bus_wdata(o_bus_wdata),
		.i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata));
	bus_mem_model u_bus_mem_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_wait(bus_wait),
		.i_req(o_bus_req), .i_we(o_bus_we), .i_addr(o_bus_addr), .i_be(o_bus_be),
		.i_wdata(o_bus_wdata), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
	always @(posedge i_clk) if (o_bus_req && i_bus_ack && !o_bus_we) rd_log.push_back(o_bus_addr[11:8]);
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		checks_done++;
		if (act !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, act, exp);
		end
	endtask
	function automatic logic [7:0] pat(input int a);
		return a[7:0] ^ a[15:8];
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Kind 0 waits for a cell, 1 for a block, 2 for more than ch logged reads.
	task automatic waitf(input int k, input int ch);
		int n = 0;
		while (!(k == 0 ? o_cell_done[ch] === 1'b1 : k == 1 ? o_block_done[ch] === 1'b1
			: rd_log.size() > ch)) begin
			cyc(1);
			n++;
			if (n > 400) begin
				err_count++;
				$display("[FAIL] %0t wait ran out", $time);
				test_done();
			end
		end
	endtask
	task automatic wr_ctrl(input int ch, input logic [7:0] d);
		cyc(1);
		i_ctrl_data = d;
		i_ctrl_wr[ch] = 1'b1;
		cyc(1);
		i_ctrl_wr = 4'h0;
	endtask
	task automatic setup(input int ch, input logic [7:0] c, input logic [31:0] sa, da,
		input logic [7:0] ss, ds, cs);
		wr_ctrl(ch, 8'h00);
		i_addr_data = sa;
		i_ssa_wr[ch] = 1'b1;
		cyc(1);
		i_ssa_wr = 4'h0;
		i_addr_data = da;
		i_dsa_wr[ch] = 1'b1;
		{i_src_size, i_dst_size, i_cell_size} = {ss, ds, cs};
		i_size_wr[ch] = 1'b1;
		cyc(1);
		{i_dsa_wr, i_size_wr} = 8'h00;
		chk({o_src_ptr[8*ch+:8], o_dst_ptr[8*ch+:8]}, 32'h0);
		wr_ctrl(ch, c);
		rd_log.delete();
		u_bus_mem_model.rd_bytes = 0;
	endtask
	task automatic go(input logic [3:0] m);
		cyc(1);
		i_start_evt = m;
		cyc(1);
		i_start_evt = 4'h0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_align;
		setup(0, 8'h81, 32'h1009, 32'h440A, 8'h64, 8'h64, 8'h09);
		go(4'h1);
		waitf(0, 0);
		chk({o_src_ptr[7:0], o_dst_ptr[7:0]}, 32'h0909);
		chk(u_bus_mem_model.rd_bytes, 9);
		for (int i = 0; i < 9; i++) chk(u_bus_mem_model.mem[32'h440A + i], pat(32'h1009 + i));
		chk(u_bus_mem_model.mem[32'h4413], pat(32'h4413));
		cyc(8);
		chk(o_src_ptr[7:0], 32'h09);
		go(4'h1);
		waitf(0, 0);
		chk({o_src_ptr[7:0], o_dst_ptr[7:0]}, 32'h1212);
	endtask
	task automatic t_wrap;
		setup(1, 8'h83, 32'h1009, 32'h4402, 8'h64, 8'h04, 8'h08);
		go(4'h2);
		waitf(0, 1);
		chk({o_src_ptr[15:8], o_dst_ptr[15:8]}, 32'h0800);
		for (int i = 0; i < 4; i++) chk(u_bus_mem_model.mem[32'h4402 + i], pat(32'h100D + i));
		chk(u_bus_mem_model.mem[32'h4406], pat(32'h4406));
	endtask
	task automatic t_block;
		setup(0, 8'h81, 32'h1011, 32'h4501, 8'h06, 8'h06, 8'h06);
		go(4'h1);
		waitf(1, 0);
		chk({o_ch_on[0], o_src_ptr[7:0], o_dst_ptr[7:0]}, 32'h0);
		chk(u_bus_mem_model.rd_bytes, 6);
	endtask
	task automatic t_prio;
		bus_wait = 2'h2;
		setup(1, 8'h83, 32'h1100, 32'h4700, 8'hC8, 8'hC8, 8'h08);
		setup(2, 8'h83, 32'h1200, 32'h4800, 8'hC8, 8'hC8, 8'h08);
		setup(0, 8'h81, 32'h1000, 32'h4600, 8'hC8, 8'hC8, 8'h08);
		go(4'h1);
		cyc(2);
		go(4'h6);
		waitf(0, 0);
		chk(rd_log.size(), 6);
		chk({rd_log[0], rd_log[5]}, 32'h0);
		chk(rd_log[1] ^ rd_log[2], 32'h3);
		chk({rd_log[3], rd_log[4]}, {rd_log[1], rd_log[2]});
	endtask
	// Suspend is a level, so the pending event must survive the whole stop.
	task automatic t_suspend;
		rd_log.delete();
		i_cfg_word = 16'h1000;
		go(4'h2);
		cyc(20);
		chk(rd_log.size(), 0);
		i_cfg_word = 16'h0000;
		waitf(0, 1);
		chk(o_src_ptr[15:8], 32'h10);
	endtask
	task automatic t_disable;
		setup(2, 8'h83, 32'h1200, 32'h4800, 8'hC8, 8'hC8, 8'h20);
		go(4'h4);
		waitf(2, 0);
		wr_ctrl(2, 8'h03);
		cyc(20);
		chk({8'(rd_log.size()), o_src_ptr[23:16], o_dst_ptr[23:16]}, {8'h1, 16'h0404});
		wr_ctrl(2, 8'h83);
		waitf(0, 2);
		chk({o_src_ptr[23:16], o_dst_ptr[23:16]}, 32'h2020);
	endtask
	task automatic t_kill;
		rd_log.delete();
		go(4'h1);
		waitf(2, 0);
		i_ectrl_data = 8'h40;
		i_ectrl_wr = 4'h1;
		cyc(1);
		i_ectrl_wr = 4'h0;
		cyc(20);
		chk({o_ch_on[0], o_src_ptr[7:0], o_dst_ptr[7:0]}, 32'h0);
		chk(rd_log.size(), 1);
		for (int i = 0; i < 4; i++) chk(u_bus_mem_model.mem[32'h4608 + i], pat(32'h1008 + i));
		chk(u_bus_mem_model.mem[32'h460C], pat(32'h460C));
	endtask
	task automatic t_evt_off;
		setup(3, 8'h40, 32'h1300, 32'h4900, 8'h04, 8'h04, 8'h04);
		go(4'h8);
		wr_ctrl(3, 8'hC0);
		waitf(1, 3);
		chk({o_ch_on[3], o_src_ptr[31:24]}, 32'h0);
		rd_log.delete();
		go(4'h8);
		i_abort_evt = 4'h8;
		cyc(1);
		i_abort_evt = 4'h0;
		wr_ctrl(3, 8'hC0);
		cyc(10);
		chk({8'(rd_log.size()), 7'h00, o_ch_on[3]}, 32'h1);
	endtask
	task automatic t_reset;
		rd_log.delete();
		go(4'h4);
		waitf(2, 0);
		i_nrst = 1'b0;
		cyc(1);
		chk({o_src_ptr | o_dst_ptr}, 32'h0);
		chk({o_ch_on, o_bus_req, o_bus_be, o_cell_done, o_block_done}, 32'h0);
		i_nrst = 1'b1;
		cyc(2);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(2);
		i_nrst = 1'b1;
		t_align();
		t_wrap();
		t_block();
		t_prio();
		t_suspend();
		t_disable();
		t_kill();
		t_evt_off();
		t_reset();
		test_done();
	end
endmodule // dma_channel_arbiter_aligner_test
